// *** hw/ocs_clock_stop_ctrl.sv ***
// What this block does
// - each request gates only its own reference output
// - request change accepted after two complement edges
// - request low restarts references within 2-6 periods
// - request high stops reference low, both undriven
// - shared pin is power-good first, then power-down
// - power-down synchronised; release powers back up
// - outputs parked before oscillators turn off
// - single-ended outputs held low after falling edge
// - differential outputs parked within four periods
// - mode 0 parks true high, complement tri-stated
// - mode 1 tri-states both sides in power-down
// - lcd clock follows dot or reference timing
// - clocks stable within 1.8 ms of power-up
// - tri-stated outputs driven high on power-down release
// - differential outputs restart together after lock
// - cpu stop seen twice, then stoppable cpu outputs stop
// - stopped cpu true high, complement tri-stated
// - cpu outputs restart within two cpu cycles
// - pci stop halts pci, free clocks keep running
// - pci outputs resume within two pci periods
// - request input honoured only when enabled
// - reference output stops with pci stop when selected
`timescale 1ns/10ps
`default_nettype none
`include "ocs_defs.svh"

module ocs_clock_stop_ctrl #(
	parameter int unsigned PWRUP_CYC =
		`OCS_PWRUP_MAX_US * 1000 / `OCS_CLK_PERIOD_NS
) (
	// system
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	// power-management inputs, asynchronous
	input wire logic [8:0] clock_request_n,
	input wire logic cpu_stop_n,
	input wire logic pci_stop_n,
	input wire logic vtt_power_good_n,
	input wire logic pll_locked,
	// differential outputs: 0-1 cpu, 2-10 reference, 11 dot, 12 lcd
	output var logic [12:0] differential_true,
	output var logic [12:0] differential_true_oe,
	output var logic [12:0] differential_complement,
	output var logic [12:0] differential_complement_oe,
	output var logic [12:0] differential_park_low_iref,
	// single-ended outputs
	output var logic [2:0] pci_clock,
	output var logic [1:0] pci_free_clock,
	// synthesizer control and state
	output var logic osc_enable,
	output var logic pll_enable,
	output var ocs_pkg::ocs_pwr_t power_state
);
	import ocs_pkg::*;

	localparam int PARK_BOUND = 12;
	localparam int CPU_BOUND = 4;
	localparam int PCI_BOUND = 14;
	localparam logic [11:0] HALVES = {`OCS_PCI_HALF, `OCS_DOT_HALF,
		`OCS_SRC_HALF, `OCS_CPU_HALF};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// clock domain of a differential channel
	function automatic logic [1:0] dom_of(input logic [3:0] k,
		input logic lcd100);
		logic [1:0] d;
		d = 2'd2;
		if (k < 4'd2)
			d = 2'd0;
		else if (k < 4'd11)
			d = 2'd1;
		else if (k == 4'd12 && lcd100)
			d = 2'd1;
		return d;
	endfunction

	// apb address decode
	function automatic ocs_rsel_t reg_sel(input logic [11:0] a);
		ocs_rsel_t s;
		s = RS_NONE;
		if (a == `OCS_REQ_EN_OFS)
			s = RS_REQ_EN;
		else if (a == `OCS_SRC_PCI_OFS)
			s = RS_SRC_PCI;
		else if (a == `OCS_CFG_OFS)
			s = RS_CFG;
		else if (a == `OCS_PD_MODE_OFS)
			s = RS_PD_MODE;
		else if (a == `OCS_STATUS_OFS)
			s = RS_STATUS;
		return s;
	endfunction

	logic [8:0] req_en_q;
	logic [8:0] src_pci_q;
	logic [8:0] cfg_q;
	logic [12:0] pd_mode_q;
	logic [3:0] ph_q;
	logic [3:0] tick;
	logic [3:0] fall;
	logic [10:0] s1_q, s2_q, prev_q, acc_q;
	logic [10:0] dtick, upd, acc_d, prev_d;
	logic pci_s1_q, pci_s2_q, lock_s1_q, lock_s2_q;
	logic role_q;
	ocs_pwr_t pwr_q, pwr_d;
	logic [19:0] lock_cnt_q;
	logic [2:0] park_cnt_q;
	logic [12:0] run_q, hold_q;
	logic [4:0] se_run_q, se_q;
	logic park, pd_park, pd_w, cpu_stop_w, pci_stop_w, all_stopped;
	logic lock_done, lcd_100;
	logic [1:0] cpu_stoppable, pci_free_clock_free;

	assign cpu_stoppable = cfg_q[`OCS_CFG_CPU_LSB +: 2];
	assign pci_free_clock_free = cfg_q[`OCS_CFG_PCI_FREE_CLOCK_LSB +: 2];
	assign lcd_100 = cfg_q[`OCS_CFG_LCD100_BIT];

	// output clock phase dividers, halted with the oscillator
	for (genvar d = 0; d < 4; d++) begin : g_div
		logic [2:0] cnt_q;
		assign tick[d] = osc_enable & (cnt_q == HALVES[d*3 +: 3] - 3'd1);
		assign fall[d] = tick[d] & ph_q[d];
		always_ff @(posedge clk) begin
			if (rst | ~osc_enable) begin
				cnt_q <= 3'h0;
				ph_q[d] <= 1'b0;
			end else if (tick[d]) begin
				cnt_q <= 3'h0;
				ph_q[d] <= ~ph_q[d];
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	assign dtick = {{2{fall[0]}}, {9{fall[1]}}};
	assign upd = dtick & ~(s2_q ^ prev_q);
	assign acc_d = (upd & s2_q) | (~upd & acc_q);
	assign prev_d = (dtick & s2_q) | (~dtick & prev_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 11'h7ff;
			s2_q <= 11'h7ff;
			prev_q <= 11'h7ff;
			acc_q <= 11'h7ff;
		end else begin
			s1_q <= {vtt_power_good_n, cpu_stop_n, clock_request_n};
			s2_q <= s1_q;
			prev_q <= prev_d;
			acc_q <= acc_d;
		end
	end

	// pci stop and lock synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			pci_s1_q <= 1'b1;
			pci_s2_q <= 1'b1;
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
		end else begin
			pci_s1_q <= pci_stop_n;
			pci_s2_q <= pci_s1_q;
			lock_s1_q <= pll_locked;
			lock_s2_q <= lock_s1_q;
		end
	end

	// stop after two samples, release at once
	assign cpu_stop_w = ~acc_q[9] & ~s2_q[9];
	// pci stop acts on the next pci edge
	assign pci_stop_w = ~pci_s2_q;
	// power-down seen on two cpu complement edges
	assign pd_w = role_q & acc_q[10] & s2_q[10];
	assign park = pwr_q != PS_RUN;
	assign pd_park = (pwr_q == PS_PARK) | (pwr_q == PS_OFF);
	assign all_stopped = ~|run_q & ~|se_run_q;
	assign lock_done = lock_cnt_q == 20'(PWRUP_CYC - 1);

	// pin becomes power-down once seen low
	always_ff @(posedge clk) begin
		if (rst)
			role_q <= 1'b0;
		else if (pwr_q == PS_WAIT_PG && ~acc_q[10])
			role_q <= 1'b1;
	end

	a_role_sticky: assert property (role_q |=> role_q)
		else $error("pin role fell back to power-good");

	// power sequencing
	always_comb begin
		pwr_d = pwr_q;
		unique case (pwr_q)
			PS_WAIT_PG: begin
				if (~acc_q[10])
					pwr_d = PS_LOCK;
			end
			// early power-down goes straight to park
			PS_LOCK: begin
				if (pd_w)
					pwr_d = PS_PARK;
				else if (lock_s2_q | lock_done)
					pwr_d = PS_RUN;
			end
			PS_RUN: begin
				if (pd_w)
					pwr_d = PS_PARK;
			end
			PS_PARK: begin
				if (all_stopped | park_cnt_q == `OCS_PARK_PERIODS)
					pwr_d = PS_OFF;
			end
			// release of power-down powers back up
			PS_OFF: begin
				if (~s2_q[10])
					pwr_d = PS_LOCK;
			end
			default: pwr_d = PS_WAIT_PG;
		endcase
	end

	// lock wait bounded by power-up time
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_q <= PS_WAIT_PG;
			lock_cnt_q <= 20'h0;
			park_cnt_q <= 3'h0;
			osc_enable <= 1'b1;
			pll_enable <= 1'b1;
		end else begin
			pwr_q <= pwr_d;
			lock_cnt_q <= (pwr_q == PS_LOCK) ? lock_cnt_q + 20'h1 : 20'h0;
			// park window counted in cpu periods
			if (pwr_q != PS_PARK)
				park_cnt_q <= 3'h0;
			else if (fall[0] && park_cnt_q != `OCS_PARK_PERIODS)
				park_cnt_q <= park_cnt_q + 3'h1;
			osc_enable <= pwr_d != PS_OFF;
			pll_enable <= pwr_d != PS_OFF;
		end
	end

	assign power_state = pwr_q;

	sequence s_park_enter;
		$rose(pwr_q == PS_PARK);
	endsequence

	a_park_window: assert property (
		s_park_enter |-> ##[1:PARK_BOUND] (pwr_q == PS_OFF))
		else $error("parking took longer than four periods");

	a_off_parked: assert property (
		(pwr_q == PS_OFF) |-> (run_q == 13'h0 && se_run_q == 5'h0))
		else $error("oscillator off with an output running");

	// differential channels
	for (genvar k = 0; k < 13; k++) begin : g_dif
		logic [1:0] dom;
		logic want, lvl, ph, tk, ev_stop, ev_go, run_d, hold_d, tri_d;
		// lcd clock picks dot or reference timing
		assign dom = dom_of(4'(k), lcd_100);
		assign ph = ph_q[dom];
		assign tk = tick[dom];
		if (k < 2) begin : g_cpu
			assign want = park | (cpu_stop_w & cpu_stoppable[k]);
			assign lvl = 1'b1;
		end else if (k < 11) begin : g_src
			// request gates its own reference output
			// ignored unless the enable bit is set
			assign want = park | (req_en_q[k-2] & acc_q[k-2]) |
				(pci_stop_w & src_pci_q[k-2]);
			assign lvl = park;
		end else begin : g_fix
			assign want = park;
			assign lvl = 1'b1;
		end
		// stop when the next edge reaches the park level
		assign ev_stop = tk & run_q[k] & want & (~ph == lvl);
		// restart together on the domain tick
		// restart on a real edge, all channels of a domain together
		assign ev_go = tk & ~run_q[k] & ~want & (~ph != hold_q[k]);
		assign run_d = (run_q[k] & ~ev_stop) | ev_go;
		assign hold_d = ev_stop ? lvl : hold_q[k];
		// mode 1 tri-states; cleared when power-down ends
		assign tri_d = pd_park & ~run_d & hold_d & pd_mode_q[k];
		always_ff @(posedge clk) begin
			if (rst) begin
				run_q[k] <= 1'b0;
				hold_q[k] <= 1'b0;
				differential_true[k] <= 1'b0;
				differential_complement[k] <= 1'b0;
				differential_true_oe[k] <= 1'b0;
				differential_complement_oe[k] <= 1'b0;
				differential_park_low_iref[k] <= 1'b0;
			end else begin
				run_q[k] <= run_d;
				hold_q[k] <= hold_d;
				// low stop leaves both sides undriven
				differential_true_oe[k] <= run_d | (hold_d & ~tri_d);
				differential_complement_oe[k] <= run_d;
				// mode 0 parks true high at reduced current
				differential_park_low_iref[k] <=
					pd_park & ~run_d & hold_d & ~pd_mode_q[k];
				if (tk & (run_q[k] | ev_go)) begin
					differential_true[k] <= ~ph;
					differential_complement[k] <= ph;
				end
			end
		end
	end

	a_src_req_low: assert property (
		(!run_q[2] && !hold_q[2]) |-> (!differential_true[2] &&
		!differential_true_oe[2] && !differential_complement_oe[2]))
		else $error("stopped reference output still driven");

	a_cpu_park_lvl: assert property (
		(pwr_q == PS_RUN && !run_q[0] && hold_q[0]) |->
		(differential_true[0] && differential_true_oe[0] &&
		!differential_complement_oe[0]))
		else $error("stopped cpu output at wrong level");

	a_mode0_high: assert property (
		(pwr_q == PS_OFF && !pd_mode_q[11] && hold_q[11]) |->
		(differential_true[11] &&
		differential_true_oe[11] && !differential_complement_oe[11] &&
		differential_park_low_iref[11]))
		else $error("mode 0 park not true-high");

	a_mode1_tri: assert property (
		(pwr_q == PS_OFF && pd_mode_q[11]) |->
		(!differential_true_oe[11] && !differential_complement_oe[11]))
		else $error("mode 1 park still driven");

	sequence s_pd_exit;
		(pwr_q == PS_OFF) ##1 (pwr_q == PS_LOCK);
	endsequence

	a_tri_release: assert property (s_pd_exit |=>
		(differential_true_oe == hold_q))
		else $error("tri-stated output not driven after release");

	a_req_gate: assert property (
		(pwr_q == PS_RUN && !pd_w && !req_en_q[0] && !pci_stop_w &&
		run_q[2]) |=> run_q[2])
		else $error("disabled request stopped its output");

	a_cpu_resume: assert property (
		($fell(cpu_stop_w) && pwr_q == PS_RUN && !pd_w) |->
		##[1:CPU_BOUND] (run_q[1:0] == 2'b11))
		else $error("cpu output late to restart");

	// single-ended channels: 0-2 pci, 3-4 pci free clocks
	for (genvar m = 0; m < 5; m++) begin : g_se
		logic free, want, ev_stop, ev_go;
		if (m < 3) begin : g_pci
			assign free = 1'b0;
		end else begin : g_pci_free_clock
			assign free = pci_free_clock_free[m-3];
		end
		assign want = park | (pci_stop_w & ~free);
		// held low from the next falling edge
		assign ev_stop = tick[3] & se_run_q[m] & want & ph_q[3];
		// resume on the next rising edge
		assign ev_go = tick[3] & ~se_run_q[m] & ~want & ~ph_q[3];
		always_ff @(posedge clk) begin
			if (rst) begin
				se_run_q[m] <= 1'b0;
				se_q[m] <= 1'b0;
			end else begin
				se_run_q[m] <= (se_run_q[m] & ~ev_stop) | ev_go;
				if (tick[3] & (se_run_q[m] | ev_go))
					se_q[m] <= ~ph_q[3];
			end
		end
	end

	assign pci_clock = se_q[2:0];
	assign pci_free_clock = se_q[4:3];

	a_se_low: assert property ((pwr_q == PS_OFF) |-> se_q == 5'h0)
		else $error("single-ended output high while off");

	a_pci_resume: assert property (
		($fell(pci_stop_w) && pwr_q == PS_RUN && !pd_w) |->
		##[1:PCI_BOUND] se_run_q[0])
		else $error("pci output late to resume");

	// apb slave: one wait state, write at the ready edge
	ocs_rsel_t sel;
	logic acc_ph, commit;
	logic [31:0] rd_w;
	assign sel = reg_sel(paddr);
	assign acc_ph = psel & penable & ~pready;
	assign commit = psel & penable & pready & pwrite;
	assign rd_w = (sel == RS_REQ_EN) ? {23'h0, req_en_q} :
		(sel == RS_SRC_PCI) ? {23'h0, src_pci_q} :
		(sel == RS_CFG) ? {23'h0, cfg_q} :
		(sel == RS_PD_MODE) ? {19'h0, pd_mode_q} :
		(sel == RS_STATUS) ? {10'h0, se_run_q, run_q, role_q, pwr_q} :
		32'h0;

	// bus handshake flops
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc_ph;
			prdata <= (acc_ph & ~pwrite) ? rd_w : 32'h0;
			pslverr <= acc_ph & (sel == RS_NONE);
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			req_en_q <= `OCS_REQ_EN_RST;
			src_pci_q <= `OCS_SRC_PCI_RST;
			cfg_q <= `OCS_CFG_RST;
			pd_mode_q <= `OCS_PD_MODE_RST;
		end else if (commit) begin
			if (sel == RS_REQ_EN)
				req_en_q <= pwdata[8:0];
			if (sel == RS_SRC_PCI)
				src_pci_q <= pwdata[8:0];
			if (sel == RS_CFG)
				cfg_q <= pwdata[8:0];
			if (sel == RS_PD_MODE)
				pd_mode_q <= pwdata[12:0];
		end
	end

endmodule

`default_nettype wire

// *** shared/ocs_defs.svh ***
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

// apb register byte offsets
`define OCS_REQ_EN_OFS 12'h000
`define OCS_SRC_PCI_OFS 12'h004
`define OCS_CFG_OFS 12'h008
`define OCS_PD_MODE_OFS 12'h00c
`define OCS_STATUS_OFS 12'h010

// reset values
`define OCS_REQ_EN_RST 9'h000
`define OCS_SRC_PCI_RST 9'h000
`define OCS_CFG_RST 9'h103
`define OCS_PD_MODE_RST 13'h0000

// configuration field positions
`define OCS_CFG_CPU_LSB 0
`define OCS_CFG_PCI_FREE_CLOCK_LSB 3
`define OCS_CFG_LCD100_BIT 8

// output clock half periods in system clock cycles
`define OCS_CPU_HALF 3'd1
`define OCS_SRC_HALF 3'd1
`define OCS_DOT_HALF 3'd1
`define OCS_PCI_HALF 3'd3

// timing
`define OCS_CLK_PERIOD_NS 5
`define OCS_PWRUP_MAX_US 1800
`define OCS_PARK_PERIODS 3'd4

`endif

// *** shared/ocs_pkg.sv ***
`default_nettype none

package ocs_pkg;

	// power sequencing states
	typedef enum logic [2:0] {
		PS_WAIT_PG = 3'b000,
		PS_LOCK = 3'b001,
		PS_RUN = 3'b010,
		PS_PARK = 3'b011,
		PS_OFF = 3'b100
	} ocs_pwr_t;

	// apb register select
	typedef enum logic [2:0] {
		RS_NONE = 3'b000,
		RS_REQ_EN = 3'b001,
		RS_SRC_PCI = 3'b010,
		RS_CFG = 3'b011,
		RS_PD_MODE = 3'b100,
		RS_STATUS = 3'b101
	} ocs_rsel_t;

endpackage

`default_nettype wire

// *** test/ocs_pm_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module ocs_pm_model (
	// system
	input wire logic clk,
	input wire logic rst,
	// wanted levels from the bench
	input wire logic [8:0] req_cmd_n,
	input wire logic cpu_cmd_n,
	input wire logic pci_cmd_n,
	input wire logic pin_cmd,
	// pins toward the generator
	output var logic [8:0] clock_request_n,
	output var logic cpu_stop_n,
	output var logic pci_stop_n,
	output var logic vtt_power_good_n
);
	// stop and request pins, idle high while in reset
	always_ff @(posedge clk) begin
		if (rst) begin
			clock_request_n <= 9'h1ff;
			cpu_stop_n <= 1'h1;
			pci_stop_n <= 1'h1;
		end else begin
			clock_request_n <= req_cmd_n;
			cpu_stop_n <= cpu_cmd_n;
			pci_stop_n <= pci_cmd_n;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			vtt_power_good_n <= 1'h1;
		end else begin
			vtt_power_good_n <= pin_cmd;
		end
	end
endmodule

`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ocs_defs.svh"

module tb;
	import ocs_pkg::*;

	localparam int LIMIT = 6000;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [8:0] req_cmd_n = 9'h1ff;
	logic cpu_cmd_n = 1'h1;
	logic pci_cmd_n = 1'h1;
	logic pin_cmd = 1'h1;
	logic pll_locked = 1'h0;
	wire logic [8:0] clock_request_n;
	wire logic cpu_stop_n;
	wire logic pci_stop_n;
	wire logic vtt_power_good_n;
	logic [12:0] d_true, d_true_oe, d_comp, d_comp_oe, d_park;
	logic [2:0] pci_clock;
	logic [1:0] pci_free_clock;
	logic osc_enable;
	logic pll_enable;
	ocs_pwr_t power_state;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	wire logic [17:0] obs = {pci_free_clock, pci_clock, d_true};

	// free-running system clock
	always #2.5 clk = ~clk;

	ocs_pm_model u_pm (.clk(clk), .rst(rst), .req_cmd_n(req_cmd_n),
		.cpu_cmd_n(cpu_cmd_n), .pci_cmd_n(pci_cmd_n), .pin_cmd(pin_cmd),
		.clock_request_n(clock_request_n), .cpu_stop_n(cpu_stop_n),
		.pci_stop_n(pci_stop_n), .vtt_power_good_n(vtt_power_good_n));

	ocs_clock_stop_ctrl #(.PWRUP_CYC(50)) DUT (.clk(clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_request_n(clock_request_n),
		.cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
		.vtt_power_good_n(vtt_power_good_n), .pll_locked(pll_locked),
		.differential_true(d_true), .differential_true_oe(d_true_oe),
		.differential_complement(d_comp),
		.differential_complement_oe(d_comp_oe),
		.differential_park_low_iref(d_park), .pci_clock(pci_clock),
		.pci_free_clock(pci_free_clock), .osc_enable(osc_enable),
		.pll_enable(pll_enable), .power_state(power_state));

	// closing report
	task automatic complete_run;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input logic e);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, e});
	endtask

	task automatic wait_state(input ocs_pwr_t s, input int lim);
		int n;
		n = 0;
		while (power_state !== s && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({29'h0, power_state}, {29'h0, s});
	endtask

	// which outputs toggle over a 16-cycle window
	task automatic activity(input int settle, input logic [17:0] exp);
		logic [17:0] prev;
		logic [17:0] act;
		act = 18'h0;
		repeat (settle) @(posedge clk);
		prev = obs;
		repeat (16) begin
			@(posedge clk);
			act = act | (obs ^ prev);
			prev = obs;
		end
		chk({14'h0, act}, {14'h0, exp});
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			failures++;
			complete_run;
		end
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		rd_chk(`OCS_REQ_EN_OFS, 32'h0, 1'h0);
		rd_chk(`OCS_SRC_PCI_OFS, 32'h0, 1'h0);
		rd_chk(`OCS_CFG_OFS, 32'h103, 1'h0);
		rd_chk(`OCS_PD_MODE_OFS, 32'h0, 1'h0);
		rd_chk(12'h020, 32'h0, 1'h1);
		chk({19'h0, d_true_oe}, 32'h0);
		@(posedge clk);
		pin_cmd <= 1'h0;
		wait_state(PS_LOCK, 20);
		wait_state(PS_RUN, 80);
		activity(4, 18'h3ffff);
		chk({19'h0, d_true_oe}, 32'h1fff);
		rd_chk(`OCS_STATUS_OFS, 32'h3ffffa, 1'h0);
		// request 0 enabled: reference 0 stops, then restarts
		apb(1'h1, `OCS_REQ_EN_OFS, 32'h1);
		activity(30, 18'h3fffb);
		chk({29'h0, d_true[2], d_true_oe[2], d_comp_oe[2]}, 32'h0);
		@(posedge clk);
		req_cmd_n <= 9'h1fe;
		activity(16, 18'h3ffff);
		// one-cycle glitch must be ignored
		req_cmd_n <= 9'h1ff;
		@(posedge clk);
		req_cmd_n <= 9'h1fe;
		repeat (16) begin
			@(posedge clk);
			chk({31'h0, d_true_oe[2]}, 32'h1);
		end
		activity(2, 18'h3ffff);
		// only cpu 1 stoppable
		apb(1'h1, `OCS_CFG_OFS, 32'h102);
		@(posedge clk);
		cpu_cmd_n <= 1'h0;
		activity(30, 18'h3fffd);
		chk({27'h0, d_true[1], d_true_oe[1], d_comp[1], d_comp_oe[1],
			d_park[1]}, 32'h18);
		@(posedge clk);
		cpu_cmd_n <= 1'h1;
		activity(8, 18'h3ffff);
		// pci free clock 0 free, reference 8 follows pci stop, lcd at 96
		apb(1'h1, `OCS_CFG_OFS, 32'h00b);
		apb(1'h1, `OCS_SRC_PCI_OFS, 32'h100);
		@(posedge clk);
		pci_cmd_n <= 1'h0;
		activity(30, 18'h11bff);
		@(posedge clk);
		pci_cmd_n <= 1'h1;
		activity(14, 18'h3ffff);
		// power-down: cpu 0 tri-stated, cpu 1 parked high
		apb(1'h1, `OCS_PD_MODE_OFS, 32'h1);
		@(posedge clk);
		pin_cmd <= 1'h1;
		wait_state(PS_OFF, 60);
		chk({30'h0, osc_enable, pll_enable}, 32'h0);
		chk({27'h0, pci_clock, pci_free_clock}, 32'h0);
		chk({30'h0, d_true_oe[0], d_comp_oe[0]}, 32'h0);
		chk({28'h0, d_true[1], d_true_oe[1], d_comp_oe[1], d_park[1]},
			32'hd);
		@(posedge clk);
		pin_cmd <= 1'h0;
		wait_state(PS_LOCK, 20);
		repeat (2) @(posedge clk);
		chk({31'h0, d_true_oe[0]}, 32'h1);
		pll_locked <= 1'h1;
		wait_state(PS_RUN, 20);
		activity(4, 18'h3ffff);
		complete_run;
	end
endmodule

`default_nettype wire
